// ==== fss_pkg.sv ====
package fss_pkg;
  localparam int unsigned CLK_MHZ = 50;

  // ****************************************
  // timing figures in their own units
  // ****************************************
  localparam int unsigned SOA_WIN_NS      = 500;
  localparam int unsigned SOA_SKIP_US     = 25;
  localparam int unsigned LS_OFF_US       = 50;
  localparam int unsigned HLDL_NS         = 450;
  localparam int unsigned LLDL_NS0        = 80;
  localparam int unsigned LLDL_STEP_NS    = 20;
  localparam int unsigned HS_GAP_US       = 30;
  localparam int unsigned HS_TOL_US       = 5;
  localparam int unsigned INT_PULSE_US    = 55;
  localparam int unsigned WAIT_MS         = 82;

  // ****************************************
  // derived cycle counts
  // ****************************************
  localparam int unsigned SOA_WIN_CYC   = SOA_WIN_NS * CLK_MHZ / 1000;
  localparam int unsigned SOA_SKIP_CYC  = SOA_SKIP_US * CLK_MHZ;
  localparam int unsigned LS_OFF_CYC    = LS_OFF_US * CLK_MHZ;
  localparam int unsigned HLDL_CYC      = HLDL_NS * CLK_MHZ / 1000;
  localparam int unsigned HS_MIN_CYC    = (HS_GAP_US - HS_TOL_US) * CLK_MHZ;
  localparam int unsigned HS_MAX_CYC    = (HS_GAP_US + HS_TOL_US) * CLK_MHZ;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned WAIT_CYC      = WAIT_MS * 1000 * CLK_MHZ;

  // ****************************************
  // line-sense levels in units of 1.25 uA (53.75 uA = 43, 7.5 uA = 6)
  // ****************************************
  localparam logic [7:0] HL_ON_LVL  = 8'h2B;
  localparam logic [7:0] HL_HYST    = 8'h06;

  // ****************************************
  // setpoints and counts
  // ****************************************
  localparam logic [11:0] VSET_DEF  = 12'h1F4;  // 5 V in 10 mV
  localparam logic [11:0] VSET_MIN  = 12'h12C;  // 3 V
  localparam logic [11:0] VSET_MAX  = 12'h960;  // 24 V
  localparam logic [7:0]  ISET_MIN  = 8'h1D;    // 15% in 0.52% steps
  localparam logic [7:0]  ISET_MAX  = 8'hC0;    // 100%
  localparam logic [3:0]  NOANS_LIM = 4'h8;
  localparam logic [3:0]  UNREQ_LIM = 4'h4;
  localparam logic [1:0]  SOA_HITS  = 2'h2;

  typedef enum logic [1:0] {
    FSS_RSP_AR   = 2'h0,
    FSS_RSP_LO   = 2'h1,
    FSS_RSP_DIS  = 2'h2,
    FSS_RSP_NONE = 2'h3
  } fss_rsp_e;

  typedef enum logic [6:0] {
    FSS_PR_INIT   = 7'b0000001,
    FSS_PR_WAIT   = 7'b0000010,
    FSS_PR_SELF   = 7'b0000100,
    FSS_PR_SLAVE  = 7'b0001000,
    FSS_PR_CLAMP  = 7'b0010000,
    FSS_PR_DELAY  = 7'b0100000,
    FSS_PR_AR     = 7'b1000000
  } fss_pr_e;
endpackage

// ==== fss_sync.sv ====
`timescale 1ns/100ps
module fss_sync
  import fss_pkg::*;
(
  input  wire logic i_clk,   // clock
  input  wire logic i_srst,  // sync reset
  input  wire logic i_d,     // async input
  output logic      o_q      // filtered level
);
  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } fss_sync_s;
  fss_sync_s st_q, st_d;

  // a change counts only once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.sh = {st_q.sh[1:0], i_d};
    if (st_q.sh[2] == st_q.sh[1]) begin
      st_d.q = st_q.sh[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_q = st_q.q;
endmodule

// ==== fss_secondary.sv ====
`timescale 1ns/100ps
module fss_secondary
  import fss_pkg::*;
(
  input  wire logic        i_clk,        // clock
  input  wire logic        i_srst,       // sync reset
  input  wire logic        i_fwd_fall,   // forward_sense falling edge pulse
  input  wire logic        i_fwd_neg,    // rectifier voltage below zero
  input  wire logic        i_ccm,        // continuous conduction mode
  input  wire logic        i_need,       // regulation wants a cycle
  input  wire logic        i_offmin_ok,  // minimum off-time elapsed
  input  wire logic        i_in_ctrl,    // secondary has control
  output logic             o_req,        // request pulse to primary
  output logic             o_sr,         // synchronous_rectifier gate
  output logic             o_rehs        // restart handshake pulse
);
  typedef struct packed {
    logic       req;
    logic       sr;
    logic       rehs;
    logic       pend;
    logic [3:0] noans;
    logic [3:0] unreq;
  } fss_sec_s;
  fss_sec_s st_q, st_d;

  always_comb begin
    st_d      = st_q;
    st_d.req  = 1'b0;
    st_d.rehs = 1'b0;
    if (i_fwd_fall && st_q.pend) begin
      st_d.sr    = 1'b1;
      st_d.pend  = 1'b0;
      st_d.noans = '0;
      st_d.unreq = '0;
    end else if (i_fwd_fall && i_in_ctrl) begin
      st_d.unreq = st_q.unreq + 4'h1;
    end
    if (!i_ccm && i_fwd_neg) begin
      st_d.sr = 1'b0;
    end
    // the forward fall restarts the off-time, so no request may share its cycle
    if (i_need && i_offmin_ok && i_in_ctrl && !st_q.req && !i_fwd_fall) begin
      if (st_q.sr) begin
        st_d.sr = 1'b0;
      end else begin
        st_d.req = 1'b1;
        if (st_q.pend) begin
          st_d.noans = st_q.noans + 4'h1;
        end
        st_d.pend = 1'b1;
      end
    end
    if (st_q.noans >= NOANS_LIM || st_q.unreq >= UNREQ_LIM) begin
      st_d.rehs  = 1'b1;
      st_d.noans = '0;
      st_d.unreq = '0;
      st_d.pend  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_req  = st_q.req;
  assign o_sr   = st_q.sr;
  assign o_rehs = st_q.rehs;
endmodule

// ==== fss_top.sv ====
`timescale 1ns/100ps
module fss_top
  import fss_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES   = WAIT_CYC,  // listen / restart on-time
  parameter int unsigned AR_OFF_CYCLES = 100000,    // auto-restart off-time
  parameter int unsigned UV_FILT_CYCLES = 1000,     // brown-out filter
  parameter int unsigned WDOG_CYCLES   = 50000000,  // host silence limit
  parameter int unsigned OFFMIN_CYCLES = 100,       // secondary min off-time
  parameter int unsigned CLAMP_CYCLES  = 10         // clamp_on_time
)(
  input  wire logic        i_clk,         // 50 MHz clock
  input  wire logic        i_srst,        // sync reset, active high
  input  wire logic        i_bp_ready,    // supply cap charged (pin)
  input  wire logic        i_current_limit_setting_hi,     // current_limit_setting strap (pin)
  input  wire logic [7:0]  i_line_lvl,    // line current, 1.25 uA units
  input  wire logic        i_line_bi,     // above brown-in (pin)
  input  wire logic        i_line_bo,     // below brown-out (pin)
  input  wire logic        i_line_ov,     // above overvoltage (pin)
  input  wire logic        i_oc110,       // 110% current limit reached (pin)
  input  wire logic [1:0]  i_clamp_rsel,  // clamp_drive_output resistor code
  input  wire logic        i_fwd_fall,    // forward_sense falling edge (pin)
  input  wire logic        i_fwd_neg,     // rectifier voltage negative (pin)
  input  wire logic        i_ccm,         // continuous mode flag
  input  wire logic        i_need,        // regulator wants a cycle
  input  wire logic        i_fb_pwr,      // secondary powered (pin)
  input  wire logic        i_fault_ouv,   // output undervoltage
  input  wire logic        i_fault_oov,   // output overvoltage
  input  wire logic        i_fault_otp,   // over-temperature
  input  wire logic [1:0]  i_rsp_ouv,     // response for undervoltage
  input  wire logic [1:0]  i_rsp_oov,     // response for overvoltage
  input  wire logic [1:0]  i_rsp_otp,     // response for over-temperature
  input  wire logic        i_host_act,    // host bus activity pulse
  input  wire logic        i_vset_wr,     // voltage setpoint write strobe
  input  wire logic [11:0] i_vset,        // voltage setpoint, 10 mV
  input  wire logic        i_iset_wr,     // current setpoint write strobe
  input  wire logic [7:0]  i_iset,        // current setpoint, 0.52%
  input  wire logic        i_bsw_open,    // host command: open bus switch
  input  wire logic        i_bsw_close,   // host command: close bus switch
  output logic             o_pswitch,     // main primary switch gate
  output logic             o_clamp,       // clamp_drive_output
  output logic             o_line_conn,   // line-sense resistor connected
  output logic             o_sr,          // synchronous_rectifier gate
  output logic             o_sreq,        // cycle request to primary
  output logic [11:0]      o_vset,        // active voltage setpoint
  output logic [7:0]       o_iset,        // active current setpoint
  output logic             o_out_en,      // output enabled
  output logic             o_bus_sw,      // bus_switch_drive
  output logic             o_scl_o,       // clock line drive value
  output logic             o_scl_oe,      // clock line enable, high pulls low
  output logic             o_slave,       // primary follows secondary
  output logic             o_ar,          // in auto-restart
  output logic             o_latched      // latched off
);
  logic bp_s, bi_s, bo_s, ov_s, oc_s, ff_s, fn_s, fb_s;
  logic req, sr, rehs;

  // ****************************************
  // pin inputs
  // ****************************************
  fss_sync u_s0 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_bp_ready), .o_q(bp_s));
  fss_sync u_s1 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_line_bi),  .o_q(bi_s));
  fss_sync u_s2 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_line_bo),  .o_q(bo_s));
  fss_sync u_s3 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_line_ov),  .o_q(ov_s));
  fss_sync u_s4 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_oc110),    .o_q(oc_s));
  fss_sync u_s5 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_fwd_fall), .o_q(ff_s));
  fss_sync u_s6 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_fwd_neg),  .o_q(fn_s));
  fss_sync u_s7 (.i_clk(i_clk), .i_srst(i_srst), .i_d(i_fb_pwr),   .o_q(fb_s));

  typedef struct packed {
    fss_pr_e     st;
    logic [31:0] tmr;
    logic [31:0] off;
    logic [31:0] uv;
    logic [31:0] gap;
    logic [31:0] soa;
    logic [7:0]  dly;
    logic [1:0]  soa_hits;
    logic [1:0]  hs_cnt;
    logic        current_limit_setting_lat;
    logic        current_limit_setting_hi;
    logic        hline;
    logic        line_conn;
    logic        fb_seen;
    logic        ff_d;
    logic        oc_d;
    logic        req_d;
    logic [31:0] offmin;
    logic [31:0] wdog;
    logic [15:0] irq;
    logic        flt_d;
    logic [11:0] vset;
    logic [7:0]  iset;
    logic        out_en;
    logic        bus_sw;
    logic        latched;
  } fss_top_s;
  fss_top_s st_q, st_d;

  logic ff_rise;
  logic line_ok;
  logic flt_any;
  logic lo_hit;
  logic ar_hit;
  logic dis_hit;
  logic [7:0] lldl_cyc;

  fss_secondary u_sec (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_fwd_fall  (ff_rise),
    .i_fwd_neg   (fn_s),
    .i_ccm       (i_ccm),
    .i_need      (i_need),
    .i_offmin_ok (st_q.offmin == '0),
    .i_in_ctrl   (fb_s && !st_q.latched && st_q.out_en),
    .o_req       (req),
    .o_sr        (sr),
    .o_rehs      (rehs)
  );

  function automatic logic resp_hit(input logic f, input logic [1:0] r, input logic [1:0] k);
    resp_hit = f && (r == k);
  endfunction

  always_comb begin
    ff_rise  = ff_s && !st_q.ff_d;
    line_ok  = bi_s && !ov_s;
    lldl_cyc = 8'((LLDL_NS0 + LLDL_STEP_NS * 32'(i_clamp_rsel)) * CLK_MHZ / 1000);
    lo_hit   = resp_hit(i_fault_ouv, i_rsp_ouv, FSS_RSP_LO) ||
               resp_hit(i_fault_oov, i_rsp_oov, FSS_RSP_LO) ||
               resp_hit(i_fault_otp, i_rsp_otp, FSS_RSP_LO);
    ar_hit   = resp_hit(i_fault_ouv, i_rsp_ouv, FSS_RSP_AR) ||
               resp_hit(i_fault_oov, i_rsp_oov, FSS_RSP_AR) ||
               resp_hit(i_fault_otp, i_rsp_otp, FSS_RSP_AR);
    dis_hit  = resp_hit(i_fault_ouv, i_rsp_ouv, FSS_RSP_DIS) ||
               resp_hit(i_fault_oov, i_rsp_oov, FSS_RSP_DIS) ||
               resp_hit(i_fault_otp, i_rsp_otp, FSS_RSP_DIS);
    flt_any  = i_fault_ouv || i_fault_oov || i_fault_otp;

    st_d       = st_q;
    st_d.ff_d  = ff_s;
    st_d.oc_d  = oc_s;
    st_d.req_d = req;
    st_d.flt_d = flt_any;

    // ****************************************
    // line monitor
    // ****************************************
    if (i_line_lvl > HL_ON_LVL) begin
      st_d.hline = 1'b1;
    end else if (i_line_lvl <= HL_ON_LVL - HL_HYST) begin
      st_d.hline = 1'b0;
    end
    st_d.uv = bo_s ? st_q.uv + 32'd1 : '0;
    if (st_q.off < 32'(LS_OFF_CYC)) begin
      st_d.off = st_q.off + 32'd1;
    end else begin
      st_d.line_conn = 1'b0;
    end

    // ****************************************
    // soa skip: two consecutive fast 110% hits
    // ****************************************
    if (st_q.soa != '0) begin
      st_d.soa = st_q.soa - 32'd1;
    end

    if (st_q.gap != '0) begin
      st_d.gap = st_q.gap + 32'd1;
    end

    // ****************************************
    // primary sequencer
    // ****************************************
    unique case (st_q.st)
      FSS_PR_INIT: begin
        st_d.tmr = '0;
        if (bp_s && !st_q.current_limit_setting_lat) begin
          st_d.current_limit_setting_lat = 1'b1;
          st_d.current_limit_setting_hi  = i_current_limit_setting_hi;
        end
        if (st_q.current_limit_setting_lat && line_ok) begin
          st_d.st     = FSS_PR_WAIT;
          st_d.hs_cnt = '0;
          st_d.gap    = '0;
        end
      end
      FSS_PR_WAIT: begin
        st_d.tmr = st_q.tmr + 32'd1;
        if (req) begin
          if (st_q.gap >= 32'(HS_MIN_CYC) && st_q.gap <= 32'(HS_MAX_CYC)) begin
            st_d.st = FSS_PR_SLAVE;
          end
          st_d.gap = 32'd1;
        end else if (st_q.gap > 32'(HS_MAX_CYC)) begin
          st_d.gap = '0;
        end
        if (st_q.tmr >= 32'(WAIT_CYCLES)) begin
          st_d.st      = FSS_PR_SELF;
          st_d.tmr     = '0;
          st_d.fb_seen = 1'b0;
        end
      end
      FSS_PR_SELF: begin
        st_d.tmr = st_q.tmr + 32'd1;
        if (req) begin
          st_d.fb_seen = 1'b1;
          st_d.st      = FSS_PR_SLAVE;
        end else if (st_q.tmr >= 32'(WAIT_CYCLES)) begin
          st_d.st  = FSS_PR_AR;
          st_d.tmr = '0;
        end else if (st_q.soa == '0 && st_q.off >= 32'(OFFMIN_CYCLES)) begin
          st_d.st  = FSS_PR_CLAMP;
          st_d.dly = '0;
        end
      end
      FSS_PR_SLAVE: begin
        st_d.tmr = '0;
        if (req && st_q.soa == '0) begin
          st_d.st  = FSS_PR_CLAMP;
          st_d.dly = '0;
        end
      end
      FSS_PR_CLAMP: begin
        st_d.line_conn = 1'b1;
        st_d.off       = '0;
        st_d.dly       = st_q.dly + 8'h01;
        if (st_q.dly >= 8'(CLAMP_CYCLES - 1)) begin
          st_d.st  = FSS_PR_DELAY;
          st_d.dly = '0;
        end
      end
      FSS_PR_DELAY: begin
        st_d.dly = st_q.dly + 8'h01;
        if (st_q.dly >= (st_q.hline ? 8'(HLDL_CYC) : lldl_cyc)) begin
          st_d.st = st_q.fb_seen ? FSS_PR_SLAVE : FSS_PR_SELF;
          st_d.soa_hits = (oc_s && st_q.dly <= 8'(SOA_WIN_CYC)) ? st_q.soa_hits + 2'h1 : '0;
          if (st_q.soa_hits + 2'h1 >= SOA_HITS && oc_s) begin
            st_d.soa      = 32'(SOA_SKIP_CYC);
            st_d.soa_hits = '0;
          end
        end
      end
      FSS_PR_AR: begin
        st_d.tmr = st_q.tmr + 32'd1;
        if (st_q.tmr >= 32'(AR_OFF_CYCLES) && line_ok) begin
          st_d.st = FSS_PR_INIT;
        end
      end
      default: st_d.st = FSS_PR_INIT;
    endcase

    // line faults override any switching state
    if (st_q.st != FSS_PR_AR && st_q.st != FSS_PR_INIT) begin
      if (st_q.uv >= 32'(UV_FILT_CYCLES) || ov_s) begin
        st_d.st      = FSS_PR_AR;
        st_d.tmr     = '0;
        st_d.fb_seen = 1'b0;
      end
    end
    if (rehs && st_d.st == FSS_PR_SLAVE) begin
      st_d.st      = FSS_PR_INIT;
      st_d.fb_seen = 1'b0;
    end
    if (st_d.st == FSS_PR_SLAVE) begin
      st_d.fb_seen = 1'b1;
    end

    // ****************************************
    // secondary setpoints, faults, watchdog
    // ****************************************
    st_d.offmin = ff_rise ? 32'(OFFMIN_CYCLES) :
                  (st_q.offmin != '0 ? st_q.offmin - 32'd1 : '0);
    if (i_vset_wr && i_vset >= VSET_MIN && i_vset <= VSET_MAX) begin
      st_d.vset = i_vset;
    end
    if (i_iset_wr && i_iset >= ISET_MIN && i_iset <= ISET_MAX) begin
      st_d.iset = i_iset;
    end
    if (lo_hit) begin
      st_d.latched = 1'b1;
    end
    if (ar_hit && st_q.st != FSS_PR_AR) begin
      st_d.st  = FSS_PR_AR;
      st_d.tmr = '0;
    end
    if (dis_hit) begin
      st_d.out_en = 1'b0;
      st_d.bus_sw = 1'b0;
    end
    // auto-restart and latch-off leave the bus switch alone
    if (i_bsw_open) begin
      st_d.bus_sw = 1'b0;
    end else if (i_bsw_close) begin
      st_d.bus_sw = 1'b1;
    end
    if (flt_any && !st_q.flt_d) begin
      st_d.irq = 16'(INT_PULSE_CYC);
    end else if (st_q.irq != '0) begin
      st_d.irq = st_q.irq - 16'h0001;
    end
    if (i_host_act) begin
      st_d.wdog = '0;
    end else if (st_q.wdog >= 32'(WDOG_CYCLES)) begin
      st_d.vset   = VSET_DEF;
      st_d.iset   = ISET_MAX;
      st_d.bus_sw = 1'b0;
      st_d.out_en = 1'b1;
      st_d.wdog   = '0;
    end else begin
      st_d.wdog = st_q.wdog + 32'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q           <= '0;
      st_q.st        <= FSS_PR_INIT;
      st_q.vset      <= VSET_DEF;
      st_q.iset      <= ISET_MAX;
      st_q.out_en    <= 1'b1;
      st_q.line_conn <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pswitch   = (st_q.st == FSS_PR_DELAY) && st_d.st != FSS_PR_DELAY && st_d.st != FSS_PR_AR &&
                       !st_q.latched;
  assign o_clamp     = (st_q.st == FSS_PR_CLAMP);
  assign o_line_conn = st_q.line_conn;
  assign o_sr        = sr;
  assign o_sreq      = req;
  assign o_vset      = st_q.vset;
  assign o_iset      = st_q.iset;
  assign o_out_en    = st_q.out_en;
  assign o_bus_sw    = st_q.bus_sw;
  assign o_scl_o     = 1'b0;
  assign o_scl_oe    = (st_q.irq != '0);
  assign o_slave     = (st_q.st == FSS_PR_SLAVE);
  assign o_ar        = (st_q.st == FSS_PR_AR);
  assign o_latched   = st_q.latched;
endmodule

// ==== fss_chk_asserts.sv ====
`timescale 1ns/100ps
module fss_chk
  import fss_pkg::*;
(
  input  wire logic        i_clk,      // clock
  input  wire logic        i_srst,     // sync reset
  input  wire logic        i_vset_wr,  // setpoint strobe
  input  wire logic [11:0] i_vset,     // setpoint value
  input  wire logic        i_bsw_open, // open command
  input  wire logic        o_pswitch,  // primary gate
  input  wire logic        o_clamp,    // clamp drive
  input  wire logic        o_sr,       // rectifier gate
  input  wire logic        o_sreq,     // request pulse
  input  wire logic [11:0] o_vset,     // voltage setpoint
  input  wire logic [7:0]  o_iset,     // current setpoint
  input  wire logic        o_bus_sw,   // bus switch
  input  wire logic        o_scl_o,    // clock line value
  input  wire logic        o_scl_oe,   // clock line enable
  input  wire logic        o_ar,       // auto-restart
  input  wire logic        o_latched   // latched off
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ****************************************
  // interrupt length counter
  // ****************************************
  logic [11:0] oe_len_q;
  always_ff @(posedge i_clk) begin
    oe_len_q <= o_scl_oe ? oe_len_q + 12'h001 : 12'h000;
  end
  // ****************************************
  // checks
  // ****************************************
  clamp_then_sw_a: assert property ($fell(o_clamp) |-> ##[3:23] (o_pswitch || o_ar))
    else $error("switch did not follow clamp");
  sw_gated_a: assert property (o_pswitch |-> !o_clamp && !o_ar && !o_latched)
    else $error("switch while clamp or halted");
  vset_range_a: assert property (o_vset >= VSET_MIN && o_vset <= VSET_MAX)
    else $error("voltage setpoint out of range");
  vset_take_a: assert property (i_vset_wr && i_vset >= VSET_MIN && i_vset <= VSET_MAX |=>
    o_vset == $past(i_vset) || o_vset == VSET_DEF)
    else $error("voltage write not taken");
  iset_range_a: assert property (o_iset >= ISET_MIN && o_iset <= ISET_MAX)
    else $error("current setpoint out of range");
  int_len_a: assert property ($fell(o_scl_oe) |-> oe_len_q == 12'(INT_PULSE_CYC))
    else $error("interrupt pulse length wrong");
  int_low_a: assert property (o_scl_oe |-> !o_scl_o)
    else $error("clock line not driven low");
  sr_req_a: assert property (o_sreq |-> !o_sr)
    else $error("rectifier on during request");
  bsw_open_a: assert property (i_bsw_open |=> !o_bus_sw)
    else $error("bus switch not opened");
  sw_seen_c: cover property (o_pswitch);
  int_seen_c: cover property ($fell(o_scl_oe));
  ar_seen_c: cover property ($rose(o_ar));
endmodule

// ==== fss_stage.sv ====
`timescale 1ns/100ps
module fss_stage (
  input  wire logic i_clk,      // clock
  input  wire logic i_pswitch,  // primary gate pulse
  input  wire logic i_slow,     // long conduction
  output logic      o_fwd_fall, // forward_sense fall
  output logic      o_fwd_neg   // rectifier current ended
);
  int cnt;
  initial begin
    cnt = 0;
    o_fwd_fall = 1'b0;
    o_fwd_neg = 1'b0;
  end
  // secondary conducts only after the primary gate ends
  always @(posedge i_clk) begin
    if (i_pswitch) cnt <= i_slow ? 80 : 30;
    else if (cnt > 0) cnt <= cnt - 1;
    // three-cycle pulses: the pin filter drops anything shorter than two cycles
    o_fwd_fall <= (cnt <= 21 && cnt >= 19);
    o_fwd_neg <= (cnt > 0 && cnt <= 3);
  end
endmodule

// ==== fss_tb.sv ====
`timescale 1ns/100ps
module testbench;
  import fss_pkg::*;
  logic i_clk, i_srst, i_bp_ready, i_current_limit_setting_hi, i_line_bi, i_line_bo, i_line_ov, i_oc110, i_ccm, i_need;
  logic i_fb_pwr, i_fault_ouv, i_fault_oov, i_fault_otp, i_host_act, i_vset_wr, i_iset_wr, i_bsw_open;
  logic i_bsw_close, slow;
  logic [7:0] i_line_lvl, i_iset;
  logic [1:0] i_clamp_rsel, i_rsp_ouv, i_rsp_oov, i_rsp_otp;
  logic [11:0] i_vset;
  wire fwd_fall, fwd_neg, o_pswitch, o_clamp, o_line_conn, o_sr, o_sreq, o_out_en, o_bus_sw;
  wire o_scl_o, o_scl_oe, o_slave, o_ar, o_latched;
  wire [11:0] o_vset;
  wire [7:0] o_iset;
  int n_errors, compares, cyc, n_sw;
  fss_top #(.WAIT_CYCLES(2000), .AR_OFF_CYCLES(500), .UV_FILT_CYCLES(20), .WDOG_CYCLES(5000),
    .OFFMIN_CYCLES(100), .CLAMP_CYCLES(10)) dut (.*, .i_fwd_fall(fwd_fall), .i_fwd_neg(fwd_neg));
  fss_stage u_stage (.i_clk(i_clk), .i_pswitch(o_pswitch), .i_slow(slow), .o_fwd_fall(fwd_fall),
    .o_fwd_neg(fwd_neg));
  initial begin
    i_clk = 0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic test_done;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // host access: strobe one cycle with a watchdog kick, look two cycles later
  task automatic wr(input logic iw, input logic [11:0] v, input logic [31:0] e);
    i_vset_wr <= !iw;
    i_iset_wr <= iw;
    i_vset <= v;
    i_iset <= v[7:0];
    i_host_act <= 1;
    tick(1);
    {i_vset_wr, i_iset_wr, i_host_act} <= 3'h0;
    tick(2);
    chk(iw ? o_iset : o_vset, e);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    n_sw += o_pswitch;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    {i_srst, i_clamp_rsel, i_line_lvl} = {1'b1, 2'h3, 8'h30};
    {i_bp_ready, i_current_limit_setting_hi, i_line_bi, i_line_bo, i_line_ov, i_oc110, i_ccm, i_need} = 8'h00;
    {i_fb_pwr, i_fault_ouv, i_fault_oov, i_fault_otp, i_host_act, i_vset_wr, i_iset_wr} = 7'h00;
    {i_bsw_open, i_bsw_close, slow, i_vset, i_iset} = '0;
    {i_rsp_ouv, i_rsp_oov, i_rsp_otp} = 6'h3F;
    tick(12);
    i_srst <= 0;
    tick(2);
    chk({o_vset, o_iset, o_bus_sw, o_line_conn}, {VSET_DEF, ISET_MAX, 2'h1});
    wr(0, 12'h12C, 12'h12C);
    wr(0, 12'h12B, 12'h12C);
    wr(0, 12'h961, 12'h12C);
    wr(0, 12'h960, 12'h960);
    wr(1, 12'h01D, 8'h1D);
    wr(1, 12'h01C, 8'h1D);
    i_bsw_close <= 1;
    tick(1);
    i_bsw_close <= 0;
    tick(2);
    chk(o_bus_sw, 1);
    {i_bsw_open, i_bsw_close} <= 2'h3;
    tick(1);
    {i_bsw_open, i_bsw_close} <= 2'h0;
    tick(2);
    chk(o_bus_sw, 0);
    {i_bsw_close, i_host_act} <= 2'h3;
    {i_fault_ouv, i_fault_oov, i_fault_otp} <= 3'h7;
    tick(1);
    {i_bsw_close, i_host_act} <= 2'h0;
    tick(10);
    chk(o_scl_oe, 1);
    tick(2800);
    chk(o_scl_oe, 0);
    tick(2400);
    chk({o_vset, o_bus_sw}, {VSET_DEF, 1'b0});
    {i_bp_ready, i_line_bi, i_line_ov, i_fb_pwr, i_need, i_ccm} <= 6'h3F;
    tick(3000);
    chk(n_sw, 0);
    i_line_ov <= 0;
    slow <= 1;
    tick(3000);
    chk(n_sw != 0, 1);
    i_line_ov <= 1;
    tick(20);
    chk(o_ar, 1);
    i_line_ov <= 0;
    tick(400);
    chk(o_ar, 1);
    tick(200);
    chk(o_ar, 0);
    {i_line_bo, i_line_bi} <= 2'h2;
    tick(40);
    chk(o_ar, 1);
    i_line_bo <= 0;
    tick(600);
    chk(o_ar, 1);
    i_line_bi <= 1;
    tick(20);
    chk(o_ar, 0);
    {i_rsp_ouv, i_rsp_oov, i_rsp_otp, i_host_act} <= {FSS_RSP_DIS, FSS_RSP_AR, FSS_RSP_LO, 1'b1};
    tick(1);
    i_host_act <= 0;
    tick(3);
    chk({o_out_en, o_latched, o_ar}, 3'h3);
    test_done();
  end
endmodule
bind fss_top fss_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_vset_wr(i_vset_wr), .i_vset(i_vset),
  .i_bsw_open(i_bsw_open), .o_pswitch(o_pswitch), .o_clamp(o_clamp), .o_sr(o_sr), .o_sreq(o_sreq),
  .o_vset(o_vset), .o_iset(o_iset), .o_bus_sw(o_bus_sw), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .o_ar(o_ar), .o_latched(o_latched));
